// ### include/pwd_defines.svh
// Offsets, field positions, reset values and widths for the prefetch window decoder
`ifndef PWD_DEFINES_SVH
`define PWD_DEFINES_SVH
`define PWD_OFS_BOTTOM 8'h24
`define PWD_OFS_TOP 8'h26
`define PWD_OFS_BOTTOM_HI 8'h28
`define PWD_OFS_TOP_HI 8'h2C
`define PWD_FIELD_MSB 15
`define PWD_FIELD_LSB 4
`define PWD_FLAG_MSB 3
`define PWD_FLAG_LSB 0
`define PWD_DW_MASK 8'hFC
`define PWD_TOP_POS 16
`define PWD_WIDE_FLAG 4'h1
`define PWD_FIELD_RST 12'h000
`define PWD_HI_RST 32'h00000000
`define PWD_LOW_ZERO 20'h00000
`define PWD_LOW_ONES 20'hFFFFF
`define PWD_CFG_OFS_W 8
`define PWD_ADDR_W 64
`endif

// ### include/pwd_pkg.sv
// Types shared by the prefetch window decoder
package pwd_pkg;
  typedef logic [63:0] pwd_addr_t;
  typedef logic [11:0] pwd_field_t;
  typedef logic [31:0] pwd_word_t;
  typedef enum logic [1:0] {
    PWD_WIN_OFF,
    PWD_WIN_ON
  } pwd_win_e;
endpackage

// ### rtl/pwd_range_cmp.sv
// Registered compare of an address against an inclusive window
`timescale 1ns/1ns
`include "pwd_defines.svh"
module pwd_range_cmp #(
  parameter int AW = `PWD_ADDR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [AW-1:0] req_addr,
  input wire logic [AW-1:0] lo,
  input wire logic [AW-1:0] hi,
  input wire logic enable,
  output logic hit,
  output logic done
);
  logic hit_r, hit_nxt;
  logic done_r, done_nxt;

  always_comb begin
    done_nxt = req_valid;
    hit_nxt = req_valid && enable && (req_addr >= lo) && (req_addr <= hi);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hit_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
      done_r <= done_nxt;
    end
  end

  assign hit = hit_r;
  assign done = done_r;
endmodule // pwd_range_cmp

// ### rtl/pwd_window_decode.sv
// Prefetchable window registers and downstream forward decision
`timescale 1ns/1ns
`include "pwd_defines.svh"
module pwd_window_decode (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [`PWD_CFG_OFS_W-1:0] CFG_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_RVALID,
  input wire logic MEM_REQ,
  input wire logic [`PWD_ADDR_W-1:0] MEM_ADDR,
  output logic FWD_HIT,
  output logic FWD_DONE,
  output logic WIN_ENABLED
);
  pwd_pkg::pwd_field_t bottom_field_r, bottom_field_nxt;
  pwd_pkg::pwd_field_t top_field_r, top_field_nxt;
  pwd_pkg::pwd_word_t bottom_hi_r, bottom_hi_nxt;
  pwd_pkg::pwd_word_t top_hi_r, top_hi_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  pwd_pkg::pwd_win_e win_r, win_nxt;
  logic win_en_r, win_en_nxt;
  pwd_pkg::pwd_addr_t base_addr, limit_addr;

  // Merge a 32-bit write into an old word under byte enables
  function automatic pwd_pkg::pwd_word_t merge_be(input pwd_pkg::pwd_word_t old, input pwd_pkg::pwd_word_t wd,
                                                  input logic [3:0] be);
    pwd_pkg::pwd_word_t res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Dword holding both 16-bit window registers, bottom low, top high
  function automatic pwd_pkg::pwd_word_t low_dword(input pwd_pkg::pwd_field_t b, input pwd_pkg::pwd_field_t t);
    return {t, `PWD_WIDE_FLAG, b, `PWD_WIDE_FLAG};
  endfunction

  // Window bounds
  always_comb begin
    base_addr = {bottom_hi_r, bottom_field_r, `PWD_LOW_ZERO};
    limit_addr = {top_hi_r, top_field_r, `PWD_LOW_ONES};
  end

  // Register writes and reads; 16-bit registers share the dword at the bottom offset
  always_comb begin
    pwd_pkg::pwd_word_t merged;
    merged = 32'h00000000;
    bottom_field_nxt = bottom_field_r;
    top_field_nxt = top_field_r;
    bottom_hi_nxt = bottom_hi_r;
    top_hi_nxt = top_hi_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (CFG_WR) begin
      unique case (CFG_ADDR & `PWD_DW_MASK)
        `PWD_OFS_BOTTOM: begin
          merged = merge_be(low_dword(bottom_field_r, top_field_r), CFG_WDATA, CFG_BE);
          bottom_field_nxt = merged[`PWD_FIELD_MSB:`PWD_FIELD_LSB];
          top_field_nxt = merged[`PWD_TOP_POS+`PWD_FIELD_MSB:`PWD_TOP_POS+`PWD_FIELD_LSB];
        end
        `PWD_OFS_BOTTOM_HI: begin
          bottom_hi_nxt = merge_be(bottom_hi_r, CFG_WDATA, CFG_BE);
        end
        `PWD_OFS_TOP_HI: begin
          top_hi_nxt = merge_be(top_hi_r, CFG_WDATA, CFG_BE);
        end
        default: begin
        end
      endcase
    end
    if (CFG_RD) begin
      rvalid_nxt = 1'b1;
      unique case (CFG_ADDR & `PWD_DW_MASK)
        `PWD_OFS_BOTTOM: rdata_nxt = low_dword(bottom_field_r, top_field_r);
        `PWD_OFS_BOTTOM_HI: rdata_nxt = bottom_hi_r;
        `PWD_OFS_TOP_HI: rdata_nxt = top_hi_r;
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Window state follows the bounds
  always_comb begin
    win_nxt = (limit_addr < base_addr) ? pwd_pkg::PWD_WIN_OFF : pwd_pkg::PWD_WIN_ON;
    win_en_nxt = (win_nxt == pwd_pkg::PWD_WIN_ON);
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      bottom_field_r <= `PWD_FIELD_RST;
      top_field_r <= `PWD_FIELD_RST;
      bottom_hi_r <= `PWD_HI_RST;
      top_hi_r <= `PWD_HI_RST;
      rdata_r <= 32'h00000000;
      rvalid_r <= 1'b0;
      win_r <= pwd_pkg::PWD_WIN_ON;
      win_en_r <= 1'b1;
    end else begin
      bottom_field_r <= bottom_field_nxt;
      top_field_r <= top_field_nxt;
      bottom_hi_r <= bottom_hi_nxt;
      top_hi_r <= top_hi_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      win_r <= win_nxt;
      win_en_r <= win_en_nxt;
    end
  end

  pwd_range_cmp #(
    .AW(`PWD_ADDR_W)
  ) u_cmp (
    .clk(MCLK),
    .rst_n(RST_N),
    .req_valid(MEM_REQ),
    .req_addr(MEM_ADDR),
    .lo(base_addr),
    .hi(limit_addr),
    .enable(limit_addr >= base_addr),
    .hit(FWD_HIT),
    .done(FWD_DONE)
  );

  assign CFG_RDATA = rdata_r;
  assign CFG_RVALID = rvalid_r;
  assign WIN_ENABLED = win_en_r;
endmodule // pwd_window_decode

// ### testbench/pwd_window_decode_properties.sv
// Port checks for the prefetch window decoder
`timescale 1ns/1ns
module pwd_window_decode_properties (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [31:0] CFG_RDATA,
  input wire logic CFG_RVALID,
  input wire logic MEM_REQ,
  input wire logic FWD_HIT,
  input wire logic FWD_DONE,
  input wire logic WIN_ENABLED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_done_after_req: assert property (MEM_REQ |=> FWD_DONE) else $error("no decision");
  a_no_idle_done: assert property (!MEM_REQ |=> !FWD_DONE) else $error("stray decision");
  a_hit_with_done: assert property (FWD_HIT |-> FWD_DONE) else $error("hit alone");
  a_rvalid_after_rd: assert property (CFG_RD |=> CFG_RVALID) else $error("no read reply");
  a_no_idle_rvalid: assert property (!CFG_RD |=> !CFG_RVALID) else $error("stray reply");
  a_flag_bits_fixed: assert property (CFG_RVALID && $past(CFG_ADDR[7:2]) == 6'h09
    |-> CFG_RDATA[3:0] == 4'h1 && CFG_RDATA[19:16] == 4'h1) else $error("flag bits");
  a_off_no_hit: assert property (MEM_REQ && !WIN_ENABLED && !$past(CFG_WR) |=> !FWD_HIT)
    else $error("hit while off");
  a_rdata_holds: assert property (!CFG_RVALID |-> $stable(CFG_RDATA)) else $error("data moved");
endmodule // pwd_window_decode_properties
bind pwd_window_decode pwd_window_decode_properties u_pwd_window_decode_properties (.*);

// ### testbench/pwd_mem_agent.sv
// Requester model that presents one memory address per call
`timescale 1ns/1ns
module pwd_mem_agent (
  input wire logic MCLK,
  input wire logic FWD_HIT,
  output logic MEM_REQ,
  output logic [63:0] MEM_ADDR
);
  initial {MEM_REQ, MEM_ADDR} = '0;
  task automatic issue(input logic [63:0] a, output logic h);
    @(negedge MCLK);
    {MEM_REQ, MEM_ADDR} = {1'b1, a};
    @(negedge MCLK);
    {MEM_REQ, MEM_ADDR} = {1'b0, ~a};
    h = FWD_HIT;
  endtask
endmodule // pwd_mem_agent

// ### testbench/tb_pwd_window_decode.sv
// Self-checking bench for the prefetch window decoder
`timescale 1ns/1ns
module tb_pwd_window_decode;
  logic MCLK, RST_N, CFG_WR, CFG_RD, MEM_REQ, FWD_HIT, FWD_DONE, WIN_ENABLED, CFG_RVALID, h;
  logic [7:0] CFG_ADDR;
  logic [3:0] CFG_BE;
  logic [31:0] CFG_WDATA, CFG_RDATA;
  logic [63:0] MEM_ADDR;
  int err_total = 0;
  int comparisons = 0;
  pwd_window_decode u_pwd_window_decode (.*);
  pwd_mem_agent u_pwd_mem_agent (.*);
  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge MCLK);
    {CFG_WR, CFG_ADDR, CFG_BE, CFG_WDATA} = {1'b1, a, b, d};
    @(negedge MCLK);
    CFG_WR = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge MCLK);
    {CFG_RD, CFG_ADDR} = {1'b1, a};
    @(negedge MCLK);
    CFG_RD = 1'b0;
    chk({CFG_RVALID, CFG_RDATA}, {1'b1, e});
  endtask
  task automatic mem(input logic [63:0] a, input logic e);
    u_pwd_mem_agent.issue(a, h);
    chk(h, e);
    chk(FWD_DONE, 1'b1);
  endtask
  task automatic give_verdict;
    $display("Errors %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {RST_N, CFG_WR, CFG_RD, CFG_ADDR, CFG_BE, CFG_WDATA} = '0;
    repeat (5) @(negedge MCLK);
    RST_N = 1'b1;
    rd(8'h24, 32'h00010001);
    chk(WIN_ENABLED, 1'b1);
    rd(8'h28, 32'h0);
    rd(8'h2C, 32'h0);
    rd(8'h30, 32'h0);
    mem(64'hFFFFF, 1'b1);
    mem(64'h100000, 1'b0);
    wr(8'h24, 4'hF, 32'hFFFFFFF0);
    rd(8'h26, 32'hFFF1FFF1);
    wr(8'h24, 4'h3, 32'h0);
    rd(8'h24, 32'hFFF10001);
    wr(8'h24, 4'hF, 32'h12301200);
    wr(8'h28, 4'hF, 32'h4);
    wr(8'h2C, 4'hF, 32'h5);
    mem(64'h4_11FFFFFF, 1'b0);
    mem(64'h4_12000000, 1'b1);
    mem(64'h4_FFF00000, 1'b1);
    mem(64'h5_123FFFFF, 1'b1);
    mem(64'h5_12400000, 1'b0);
    wr(8'h2C, 4'hF, 32'h3);
    mem(64'h4_12000000, 1'b0);
    chk(WIN_ENABLED, 1'b0);
    give_verdict();
  end
endmodule // tb_pwd_window_decode
